// >>> hw/evq_event_unit.sv
// capture fifos, quadrature decoder and grouped event flags with vector select
// How it works
// - three capture units each keep a two-entry fifo; top holds oldest value
// - reading the top entry moves the bottom value up
// - bottom read with status 10 or 11 sets status 01
// - bottom read with status 01 sets status 00
// - capture into empty fifo fills top, status 01; read empties it
// - capture with one entry fills bottom, status 10
// - read of two-entry fifo returns top, shifts bottom up, status 01
// - capture when full drops oldest, shifts, stores new, status 11
// - capture into non-empty fifo sets the unit's capture flag
// - quadrature mode decodes both shared pins and stops captures one and two
// - decoder supplies clock and direction to timer 2, set up by software
// - direction is up when input a leads, down when b leads
// - one count pulse per edge of either input, four per period
// - timer 2 keeps its own count and ignores its pins in this mode
// - timer flags on reaching 0000h, ffffh, compare or period
// - three flag groups, each with flag and mask registers
// - a flag requests an interrupt only when its mask bit is one
// - fixed vector and priority for every source
// - vector shown is the highest priority set and enabled source
// - flags stay until software writes one; no new request meanwhile
// - sixteen-bit flag registers, unused bits read zero, group a layout
// - control field 11 enables decoder and disables captures one and two
`timescale 1ns/1ps
`default_nettype none
module evq_event_unit
(
	input wire logic clock,
	input wire logic reset_n,
	input wire evq_pkg::evq_bus_t bus,
	output logic [15:0] rdata,
	input wire logic [2:0] cap_pin,
	input wire evq_pkg::evq_timer_t tim1,
	input wire evq_pkg::evq_timer_t tim2,
	input wire evq_pkg::evq_event_t events,
	output evq_pkg::evq_quad_t quad_out,
	output evq_pkg::evq_irq_t irq_out
);
	import evq_pkg::*;

	evq_state_t st;
	evq_state_t n;
	logic [2:0] rise;
	logic [2:0] fall;
	logic [2:0] cap;
	logic [2:0] cap_en;
	logic [2:0] cap_hit;
	logic [1:0] s;
	logic [1:0] edge_cfg;
	logic [15:0] val;
	logic [15:0] set_a;
	logic [15:0] set_b;
	logic [15:0] set_c;
	logic quad_on;
	logic edge_a;
	logic edge_b;

	// returns {overflow, underflow, compare, period}, only on a count change
	function automatic logic [3:0] timer_events(input evq_timer_t t, input logic [15:0] prev);
		logic chg;
		chg = t.count != prev;
		return {chg && t.count == CNT_MAX, chg && t.count == CNT_ZERO,
			chg && t.count == t.compare, chg && t.count == t.period};
	endfunction

	// lowest set bit has highest priority; gap marks where vector numbering jumps
	function automatic logic [7:0] pick_vector(input logic [15:0] p, input logic [7:0] lo,
		input logic [7:0] hi, input int gap);
		logic [7:0] v;
		v = '0;
		for (int i = 15; i >= 0; i--)
		begin
			if (p[i])
			begin
				v = (i >= gap) ? hi + 8'(i - gap) : lo + 8'(i);
			end
		end
		return v;
	endfunction

	always_comb
	begin
		n = st;
		cap = '0;
		cap_hit = '0;
		s = '0;
		edge_cfg = '0;
		val = '0;
		// pins pass two stages before any edge logic sees them
		n.sync1 = cap_pin;
		n.sync2 = st.sync1;
		n.prev = st.sync2;
		rise = st.sync2 & ~st.prev;
		fall = ~st.sync2 & st.prev;
		quad_on = st.ctrl[CC_QSEL +: 2] == QSEL_QUAD;
		cap_en = {st.ctrl[CC_CAP3EN], {2{st.ctrl[CC_QSEL +: 2] == QSEL_CAP}}};

		for (int u = 0; u < 3; u++)
		begin
			edge_cfg = st.ctrl[CC_EDGE1 - 2 * u +: 2];
			cap[u] = cap_en[u] && ((edge_cfg[0] && rise[u]) || (edge_cfg[1] && fall[u]));
			val = ((u == 2) ? st.ctrl[CC_T3SEL] : st.ctrl[CC_T12SEL]) ? tim1.count : tim2.count;
			s = st.fill[u];
			// a read in the same cycle as a capture is handled first
			if (bus.rd && bus.addr == ADDR_TOP0 + 16'(u))
			begin
				if (s == FILL_ONE)
				begin
					s = FILL_EMPTY;
				end
				else if (s != FILL_EMPTY)
				begin
					n.top[u] = st.bot[u];
					s = FILL_ONE;
				end
			end
			if (bus.rd && bus.addr == ADDR_BOT0 + 16'(u))
			begin
				if (s == FILL_ONE)
				begin
					s = FILL_EMPTY;
				end
				else if (s != FILL_EMPTY)
				begin
					s = FILL_ONE;
				end
			end
			if (cap[u])
			begin
				cap_hit[u] = s != FILL_EMPTY;
				if (s == FILL_EMPTY)
				begin
					n.top[u] = val;
					s = FILL_ONE;
				end
				else if (s == FILL_ONE)
				begin
					n.bot[u] = val;
					s = FILL_TWO;
				end
				else
				begin
					// oldest value is lost; status remembers it
					n.top[u] = n.bot[u];
					n.bot[u] = val;
					s = FILL_LOST;
				end
			end
			n.fill[u] = s;
			// a software write of the status beats a capture
			if (bus.wr && bus.addr == ADDR_FILL)
			begin
				n.fill[u] = bus.wdata[FILL_LO + 2 * u +: 2];
			end
		end

		if (bus.wr && bus.addr == ADDR_CTRL)
		begin
			n.ctrl = bus.wdata & CC_WMASK;
			// writing zero to the reset bit wipes all fifo contents
			if (!bus.wdata[CC_RESET])
			begin
				n.top = '0;
				n.bot = '0;
				n.fill = '0;
			end
		end

		// timer 2 runs on these pulses from its own count; its pins are not used
		edge_a = st.sync2[0] ^ st.prev[0];
		edge_b = st.sync2[1] ^ st.prev[1];
		n.quad.count_pulse = quad_on && (edge_a ^ edge_b);
		if (quad_on && (edge_a ^ edge_b))
		begin
			// a simultaneous change on both pins is invalid and dropped
			n.quad.dir_up = st.sync2[0] ^ st.prev[1];
		end
		// timer flags fire only when a count arrives at a match, not while it rests there
		n.t1_prev = tim1.count;
		n.t2_prev = tim2.count;

		set_a = '0;
		set_a[BIT_PDP] = events.power_protect;
		set_a[BIT_CMP1 +: 3] = events.compare;
		set_a[BIT_T1P +: 4] = timer_events(tim1, st.t1_prev);
		set_b = {12'h000, timer_events(tim2, st.t2_prev)};
		set_c = {13'h0000, cap_hit};

		// flags clear on a written one; a new event in that cycle wins
		n.flag_a = ((st.flag_a & ~((bus.wr && bus.addr == ADDR_FLAG_A) ? bus.wdata : 16'h0000))
			| set_a) & FLAG_A_BITS;
		n.flag_b = ((st.flag_b & ~((bus.wr && bus.addr == ADDR_FLAG_B) ? bus.wdata : 16'h0000))
			| set_b) & FLAG_B_BITS;
		n.flag_c = ((st.flag_c & ~((bus.wr && bus.addr == ADDR_FLAG_C) ? bus.wdata : 16'h0000))
			| set_c) & FLAG_C_BITS;
		if (bus.wr && bus.addr == ADDR_MASK_A)
		begin
			n.mask_a = bus.wdata & FLAG_A_BITS;
		end
		if (bus.wr && bus.addr == ADDR_MASK_B)
		begin
			n.mask_b = bus.wdata & FLAG_B_BITS;
		end
		if (bus.wr && bus.addr == ADDR_MASK_C)
		begin
			n.mask_c = bus.wdata & FLAG_C_BITS;
		end

		// request is a level per group; an uncleared flag cannot pulse again
		n.irq.req[0] = |(n.flag_a & n.mask_a);
		n.irq.req[1] = |(n.flag_b & n.mask_b);
		n.irq.req[2] = |(n.flag_c & n.mask_c);
		n.irq.vector[0] = pick_vector(n.flag_a & n.mask_a, VEC_PDP, VEC_T1P, BIT_T1P);
		n.irq.vector[1] = pick_vector(n.flag_b & n.mask_b, VEC_T2P, VEC_T2P, NO_GAP);
		n.irq.vector[2] = pick_vector(n.flag_c & n.mask_c, VEC_CAP1, VEC_CAP1, NO_GAP);

		n.rdata = '0;
		if (bus.rd)
		begin
			case (bus.addr)
				ADDR_CTRL: n.rdata = st.ctrl;
				ADDR_FILL: n.rdata = {2'h0, st.fill, 8'h00};
				ADDR_MASK_A: n.rdata = st.mask_a;
				ADDR_MASK_B: n.rdata = st.mask_b;
				ADDR_MASK_C: n.rdata = st.mask_c;
				ADDR_FLAG_A: n.rdata = st.flag_a;
				ADDR_FLAG_B: n.rdata = st.flag_b;
				ADDR_FLAG_C: n.rdata = st.flag_c;
				default: n.rdata = '0;
			endcase
			for (int u = 0; u < 3; u++)
			begin
				if (bus.addr == ADDR_TOP0 + 16'(u))
				begin
					n.rdata = st.top[u];
				end
				if (bus.addr == ADDR_BOT0 + 16'(u))
				begin
					n.rdata = st.bot[u];
				end
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st <= ST_RESET;
		end
		else
		begin
			st <= n;
		end
	end

	assign rdata = st.rdata;
	assign quad_out = st.quad;
	assign irq_out = st.irq;

	// unit three stands for all three fifos; it is the one the bench drives
	wire logic quiet2 = !bus.wr && !cap[2];

	a_top_pop: assert property (@(posedge clock) disable iff (!reset_n)
		bus.rd && bus.addr == ADDR_TOP0 + 16'h0002 && st.fill[2] == FILL_TWO && quiet2
		|=> st.fill[2] == FILL_ONE && st.top[2] == $past(st.bot[2]))
		else $error("top read of full fifo did not shift");
	a_bot_read_one: assert property (@(posedge clock) disable iff (!reset_n)
		bus.rd && bus.addr == ADDR_BOT0 + 16'h0002 && st.fill[2] == FILL_ONE && quiet2
		|=> st.fill[2] == FILL_EMPTY)
		else $error("bottom read did not empty fifo");
	a_bot_read_lost: assert property (@(posedge clock) disable iff (!reset_n)
		bus.rd && bus.addr == ADDR_BOT0 + 16'h0002 && st.fill[2] == FILL_LOST && quiet2
		|=> st.fill[2] == FILL_ONE)
		else $error("bottom read did not leave one entry");
	a_first_cap: assert property (@(posedge clock) disable iff (!reset_n)
		cap[2] && st.fill[2] == FILL_EMPTY && !bus.rd && !bus.wr
		|=> st.fill[2] == FILL_ONE
		&& st.top[2] == $past(st.ctrl[CC_T3SEL] ? tim1.count : tim2.count))
		else $error("first capture not stored in top");
	a_overrun: assert property (@(posedge clock) disable iff (!reset_n)
		cap[2] && st.fill[2] == FILL_TWO && !bus.rd && !bus.wr
		|=> st.fill[2] == FILL_LOST && st.top[2] == $past(st.bot[2]))
		else $error("overrun capture mishandled");
	a_cap_flag: assert property (@(posedge clock) disable iff (!reset_n)
		cap[2] && st.fill[2] != FILL_EMPTY && !bus.rd |=> st.flag_c[2])
		else $error("capture flag not set");
	a_quad_blocks: assert property (@(posedge clock) disable iff (!reset_n)
		quad_on && !bus.rd && !bus.wr |=> $stable(st.fill[1:0]))
		else $error("capture ran in quadrature mode");
	a_quad_pulse: assert property (@(posedge clock) disable iff (!reset_n)
		quad_on && st.sync2[0] != st.prev[0] && st.sync2[1] == st.prev[1]
		|=> st.quad.count_pulse)
		else $error("quadrature edge gave no pulse");
	a_quad_dir: assert property (@(posedge clock) disable iff (!reset_n)
		st.quad.count_pulse && $past(st.sync2[0]) && !$past(st.prev[0]) && !$past(st.sync2[1])
		|-> st.quad.dir_up)
		else $error("a leading b did not count up");
	a_flag_hold: assert property (@(posedge clock) disable iff (!reset_n)
		st.flag_c[0] && !(bus.wr && bus.addr == ADDR_FLAG_C && bus.wdata[0]) |=> st.flag_c[0])
		else $error("flag cleared without a write of one");
	a_mask_off: assert property (@(posedge clock) disable iff (!reset_n)
		(st.mask_b == 16'h0000) [*2] |-> !st.irq.req[1])
		else $error("masked flag raised a request");
	a_vector_top: assert property (@(posedge clock) disable iff (!reset_n)
		$past(bus.wr) == 1'b0 && st.flag_a[BIT_PDP] && st.mask_a[BIT_PDP] && $past(st.flag_a[BIT_PDP])
		&& $past(st.mask_a[BIT_PDP]) |-> st.irq.vector[0] == VEC_PDP)
		else $error("wrong vector for highest source");
	a_timer_uf: assert property (@(posedge clock) disable iff (!reset_n)
		tim2.count == CNT_ZERO && st.t2_prev != CNT_ZERO |=> st.flag_b[BIT_UF])
		else $error("timer underflow flag missing");
	a_flag_zero: assert property (@(posedge clock) disable iff (!reset_n)
		$past(bus.rd) && $past(bus.addr) == ADDR_FLAG_A |-> st.rdata[15:11] == 5'h00)
		else $error("unused flag bits read nonzero");
	a_second_cap: assert property (@(posedge clock) disable iff (!reset_n)
		cap[2] && st.fill[2] == FILL_ONE && !bus.rd && !bus.wr
		|=> st.fill[2] == FILL_TWO
		&& st.bot[2] == $past(st.ctrl[CC_T3SEL] ? tim1.count : tim2.count))
		else $error("second capture not stored in bottom");
	a_first_quiet: assert property (@(posedge clock) disable iff (!reset_n)
		cap[2] && st.fill[2] == FILL_EMPTY && !bus.rd && !bus.wr && !st.flag_c[2]
		|=> !st.flag_c[2])
		else $error("capture into empty fifo set its flag");
	a_top_data: assert property (@(posedge clock) disable iff (!reset_n)
		bus.rd && bus.addr == ADDR_TOP0 + 16'h0002 |=> st.rdata == $past(st.top[2]))
		else $error("top read returned wrong value");
	a_flag_clear: assert property (@(posedge clock) disable iff (!reset_n)
		bus.wr && bus.addr == ADDR_FLAG_C && bus.wdata[2] && !cap[2] |=> !st.flag_c[2])
		else $error("written one did not clear flag");
	a_cap_blocked: assert property (@(posedge clock) disable iff (!reset_n)
		quad_on |-> cap[1:0] == 2'b00)
		else $error("shared pins captured in quadrature mode");
	a_quad_idle: assert property (@(posedge clock) disable iff (!reset_n)
		!quad_on |=> !st.quad.count_pulse)
		else $error("decoder counted while disabled");
	a_sync_path: assert property (@(posedge clock) disable iff (!reset_n)
		st.sync2 == $past(st.sync1))
		else $error("pin synchroniser skipped a stage");
	a_flag_unused: assert property (@(posedge clock) disable iff (!reset_n)
		st.flag_a[15:11] == 5'h00 && st.flag_a[6:4] == 3'h0
		&& st.flag_b[15:4] == 12'h000 && st.flag_c[15:3] == 13'h0)
		else $error("unused flag bit set");
	a_mask_unused: assert property (@(posedge clock) disable iff (!reset_n)
		st.mask_a[15:11] == 5'h00 && st.mask_a[6:4] == 3'h0
		&& st.mask_b[15:4] == 12'h000 && st.mask_c[15:3] == 13'h0)
		else $error("unused mask bit set");
	a_req_a: assert property (@(posedge clock) disable iff (!reset_n)
		st.irq.req[0] == |(st.flag_a & st.mask_a))
		else $error("group a request disagrees with flags");
	a_req_c: assert property (@(posedge clock) disable iff (!reset_n)
		st.irq.req[2] == |(st.flag_c & st.mask_c))
		else $error("group c request disagrees with flags");
	a_vector_cmp: assert property (@(posedge clock) disable iff (!reset_n)
		st.flag_a[3:0] == 4'ha && st.mask_a[1] |-> st.irq.vector[0] == VEC_PDP + 8'h01)
		else $error("compare one vector not chosen");
	a_vector_t2: assert property (@(posedge clock) disable iff (!reset_n)
		st.flag_b[3:0] == 4'h8 && st.mask_b[3] |-> st.irq.vector[1] == VEC_T2P + 8'h03)
		else $error("timer 2 overflow vector wrong");
	a_vector_c: assert property (@(posedge clock) disable iff (!reset_n)
		st.flag_c[2:0] == 3'h4 && st.mask_c[2] |-> st.irq.vector[2] == VEC_CAP1 + 8'h02)
		else $error("capture 3 vector wrong");
	a_vector_none: assert property (@(posedge clock) disable iff (!reset_n)
		(st.flag_b & st.mask_b) == 16'h0000 |-> st.irq.vector[1] == 8'h00)
		else $error("vector shown with no enabled flag");

	c_overrun: cover property (@(posedge clock) disable iff (!reset_n) st.fill[2] == FILL_LOST);
	c_quad_down: cover property (@(posedge clock) disable iff (!reset_n)
		st.quad.count_pulse && !st.quad.dir_up);
	c_irq_c: cover property (@(posedge clock) disable iff (!reset_n) st.irq.req[2]);
	c_pop_cap: cover property (@(posedge clock) disable iff (!reset_n)
		cap[2] && bus.rd && bus.addr == ADDR_TOP0 + 16'h0002);
endmodule
`default_nettype wire

// >>> hw/evq_pkg.sv
// constants and carrier types for the capture fifo, quadrature and event flag block
`default_nettype none
package evq_pkg;
	localparam logic [15:0] ADDR_CTRL = 16'h7420;
	localparam logic [15:0] ADDR_FILL = 16'h7422;
	localparam logic [15:0] ADDR_TOP0 = 16'h7423;
	localparam logic [15:0] ADDR_BOT0 = 16'h7427;
	localparam logic [15:0] ADDR_MASK_A = 16'h742c;
	localparam logic [15:0] ADDR_MASK_B = 16'h742d;
	localparam logic [15:0] ADDR_MASK_C = 16'h742e;
	localparam logic [15:0] ADDR_FLAG_A = 16'h742f;
	localparam logic [15:0] ADDR_FLAG_B = 16'h7430;
	localparam logic [15:0] ADDR_FLAG_C = 16'h7431;
	localparam int CC_RESET = 15;
	localparam int CC_QSEL = 13;
	localparam int CC_CAP3EN = 12;
	localparam int CC_T3SEL = 10;
	localparam int CC_T12SEL = 9;
	localparam int CC_EDGE1 = 6;
	localparam int FILL_LO = 8;
	localparam logic [15:0] CC_WMASK = 16'h77fc;
	localparam logic [1:0] QSEL_CAP = 2'h1;
	localparam logic [1:0] QSEL_QUAD = 2'h3;
	localparam logic [1:0] FILL_EMPTY = 2'h0;
	localparam logic [1:0] FILL_ONE = 2'h1;
	localparam logic [1:0] FILL_TWO = 2'h2;
	localparam logic [1:0] FILL_LOST = 2'h3;
	localparam logic [15:0] FLAG_A_BITS = 16'h078f;
	localparam logic [15:0] FLAG_B_BITS = 16'h000f;
	localparam logic [15:0] FLAG_C_BITS = 16'h0007;
	localparam logic [15:0] MASK_A_RST = 16'h0001;
	localparam int BIT_PDP = 0;
	localparam int BIT_CMP1 = 1;
	localparam int BIT_T1P = 7;
	localparam int BIT_UF = 2;
	localparam int NO_GAP = 16;
	localparam logic [7:0] VEC_PDP = 8'h20;
	localparam logic [7:0] VEC_T1P = 8'h27;
	localparam logic [7:0] VEC_T2P = 8'h2b;
	localparam logic [7:0] VEC_CAP1 = 8'h33;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hffff;

	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} evq_bus_t;

	typedef struct packed {
		logic [15:0] count;
		logic [15:0] compare;
		logic [15:0] period;
	} evq_timer_t;

	typedef struct packed {
		logic power_protect;
		logic [2:0] compare;
	} evq_event_t;

	typedef struct packed {
		logic count_pulse;
		logic dir_up;
	} evq_quad_t;

	typedef struct packed {
		logic [2:0] req;
		logic [2:0][7:0] vector;
	} evq_irq_t;

	typedef struct packed {
		logic [15:0] ctrl;
		logic [2:0][1:0] fill;
		logic [2:0][15:0] top;
		logic [2:0][15:0] bot;
		logic [15:0] mask_a;
		logic [15:0] mask_b;
		logic [15:0] mask_c;
		logic [15:0] flag_a;
		logic [15:0] flag_b;
		logic [15:0] flag_c;
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic [2:0] prev;
		logic [15:0] t1_prev;
		logic [15:0] t2_prev;
		logic [15:0] rdata;
		evq_irq_t irq;
		evq_quad_t quad;
	} evq_state_t;

	localparam evq_state_t ST_RESET = '{mask_a: MASK_A_RST, default: '0};
endpackage
`default_nettype wire

// >>> tb/evq_encoder.sv
// edge source and quadrature encoder model driving the capture pins
`timescale 1ns/1ps
`default_nettype none
module evq_encoder
(
	input wire logic clock,
	output logic [2:0] pins
);
	int pos;
	initial
	begin
		pins = 3'h0;
		pos = 0;
	end
	// quarter period per call, held five clocks: the decoder needs two
	task automatic quad_step(input bit fwd);
		pos = fwd ? (pos + 1) % 4 : (pos + 3) % 4;
		@(posedge clock);
		pins[1:0] <= (pos == 0) ? 2'h0 : (pos == 1) ? 2'h1 : (pos == 2) ? 2'h3 : 2'h2;
		repeat (4) @(posedge clock);
	endtask
	task automatic pulse_unit3();
		@(posedge clock);
		pins[2] <= 1'b1;
		repeat (4) @(posedge clock);
		pins[2] <= 1'b0;
		repeat (4) @(posedge clock);
	endtask
endmodule
`default_nettype wire

// >>> tb/capture_fifo_quadrature_irq_tb.sv
// self-checking bench for the capture fifo, quadrature and event flag block
`timescale 1ns/1ps
`default_nettype none
module capture_fifo_quadrature_irq_tb;
	import evq_pkg::*;
	logic clock;
	logic reset_n;
	evq_bus_t bus;
	logic [15:0] rdata;
	logic [2:0] cap_pin;
	evq_timer_t tim1;
	evq_timer_t tim2;
	evq_event_t events;
	evq_quad_t quad_out;
	evq_irq_t irq_out;
	int bad_count;
	int check_count;
	int pulses;
	int p0;
	int q[$];
	logic [15:0] d;
	logic [15:0] v;
	evq_event_unit DUT (.clock(clock), .reset_n(reset_n), .bus(bus), .rdata(rdata),
		.cap_pin(cap_pin), .tim1(tim1), .tim2(tim2), .events(events),
		.quad_out(quad_out), .irq_out(irq_out));
	evq_encoder enc (.clock(clock), .pins(cap_pin));
	task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %0t register %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %0t output %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] w);
		@(posedge clock);
		bus <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		bus.wr <= 1'b0;
	endtask
	task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
		@(posedge clock);
		bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		bus.rd <= 1'b0;
		#1 chk_reg(rdata, exp);
	endtask
	// unit 3 samples timer 1; values kept clear of timer 1 match points
	task automatic capture3();
		v = 16'($urandom() & 32'h0fff) + 16'h0001;
		@(posedge clock);
		tim1.count <= v;
		if (q.size() > 1)
			void'(q.pop_front());
		q.push_back(int'(v));
		enc.pulse_unit3();
	endtask
	task automatic ev(input evq_event_t e);
		@(posedge clock);
		events <= e;
		@(posedge clock);
		events <= '0;
		@(posedge clock);
		#1;
	endtask
	task automatic tim2_to(input logic [15:0] c);
		@(posedge clock);
		tim2.count <= c;
		repeat (2) @(posedge clock);
		#1;
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	always @(posedge clock)
		if (quad_out.count_pulse === 1'b1)
			pulses <= pulses + 1;
	initial
	begin
		repeat (20000) @(posedge clock);
		bad_count++;
		end_sim();
	end
	initial
	begin
		reset_n = 1'b0;
		bus = '0;
		tim1 = '{count: 16'h0000, compare: 16'hfff1, period: 16'hfff0};
		tim2 = '0;
		events = '0;
		bad_count = 0;
		check_count = 0;
		pulses = 0;
		void'($urandom(77678));
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		rchk(ADDR_MASK_A, MASK_A_RST);
		rchk(ADDR_FLAG_A, 16'h0000);
		rchk(16'h7426, 16'h0000);
		// unit 3 on, rising edges, timer 1
		wr(ADDR_CTRL, 16'h3404);
		wr(ADDR_MASK_C, 16'h0004);
		capture3();
		rchk(ADDR_FILL, 16'h1000);
		rchk(ADDR_FLAG_C, 16'h0000);
		capture3();
		rchk(ADDR_FILL, 16'h2000);
		rchk(ADDR_FLAG_C, 16'h0004);
		chk_out(irq_out.vector[2], 8'h35);
		chk_out({7'h00, irq_out.req[2]}, 8'h01);
		capture3();
		rchk(ADDR_FILL, 16'h3000);
		rchk(ADDR_BOT0 + 16'h0002, 16'(q[1]));
		rchk(ADDR_FILL, 16'h1000);
		rchk(ADDR_TOP0 + 16'h0002, 16'(q[0]));
		rchk(ADDR_FILL, 16'h0000);
		q.delete();
		capture3();
		capture3();
		rchk(ADDR_TOP0 + 16'h0002, 16'(q[0]));
		rchk(ADDR_FILL, 16'h1000);
		rchk(ADDR_TOP0 + 16'h0002, 16'(q[1]));
		// a top read copies the bottom up without clearing it, so the bottom keeps this value
		d = 16'(q[1]);
		q.delete();
		capture3();
		rchk(ADDR_BOT0 + 16'h0002, d);
		rchk(ADDR_FILL, 16'h0000);
		wr(ADDR_FLAG_C, 16'h0004);
		rchk(ADDR_FLAG_C, 16'h0000);
		chk_out({7'h00, irq_out.req[2]}, 8'h00);
		// timer 2 preloaded before the decoder is switched on
		@(posedge clock);
		tim2 <= '{count: 16'h0100, compare: 16'h0200, period: 16'h0300};
		wr(ADDR_CTRL, 16'h60c0);
		p0 = pulses;
		repeat (4) enc.quad_step(1'b1);
		#1 chk_out(8'(pulses - p0), 8'h04);
		chk_out({7'h00, quad_out.dir_up}, 8'h01);
		p0 = pulses;
		repeat (8) enc.quad_step(1'b0);
		#1 chk_out(8'(pulses - p0), 8'h08);
		chk_out({7'h00, quad_out.dir_up}, 8'h00);
		rchk(ADDR_FILL, 16'h0000);
		rchk(ADDR_FLAG_C, 16'h0000);
		// group a priority, masking and write-one clear
		wr(ADDR_MASK_A, 16'hffff);
		rchk(ADDR_MASK_A, FLAG_A_BITS);
		wr(ADDR_FLAG_A, 16'hffff);
		ev('{power_protect: 1'b0, compare: 3'b101});
		chk_out(irq_out.vector[0], 8'h21);
		rchk(ADDR_FLAG_A, 16'h000a);
		ev('{power_protect: 1'b1, compare: 3'b000});
		chk_out(irq_out.vector[0], VEC_PDP);
		wr(ADDR_FLAG_A, 16'h0001);
		@(posedge clock);
		#1 chk_out(irq_out.vector[0], 8'h21);
		wr(ADDR_MASK_A, 16'h0000);
		@(posedge clock);
		#1 chk_out({7'h00, irq_out.req[0]}, 8'h00);
		rchk(ADDR_FLAG_A, 16'h000a);
		// timer 2 period, compare, underflow, overflow in quadrature mode
		wr(ADDR_MASK_B, 16'h000f);
		for (int i = 0; i < 4; i++)
		begin
			tim2_to(i == 0 ? 16'h0300 : i == 1 ? 16'h0200 : i == 2 ? CNT_ZERO : CNT_MAX);
			chk_out(irq_out.vector[1], VEC_T2P + 8'(i));
			chk_out({7'h00, irq_out.req[1]}, 8'h01);
			rchk(ADDR_FLAG_B, 16'h0001 << i);
			wr(ADDR_FLAG_B, 16'h0001 << i);
		end
		rchk(ADDR_FLAG_B, 16'h0000);
		end_sim();
	end
endmodule
`default_nettype wire
